// ==== hdl/cfas_defs.svh ====
// Constants for the condition flags and address sequencing block
`ifndef CFAS_DEFS_SVH
`define CFAS_DEFS_SVH
`define CFAS_FLAGS_RESET   8'h01
`define CFAS_EDIT_LOW_BYTE 8'h20
`define CFAS_BIT_ZERO      3'd7
`define CFAS_BIT_NEG       3'd6
`define CFAS_BIT_POS       3'd5
`define CFAS_BIT_OVF       3'd4
`define CFAS_BIT_TEST      3'd3
`define CFAS_BIT_CARRY     3'd2
`define CFAS_ADDR_FLAGS    4'h0
`define CFAS_ADDR_IAR      4'h1
`define CFAS_ADDR_SAR      4'h2
`define CFAS_ADDR_OPA      4'h3
`define CFAS_ADDR_XR1      4'h4
`define CFAS_ADDR_XR2      4'h5
`endif

// ==== hdl/cfas_pkg.sv ====
// Types for the condition flags and address sequencing block
package cfas_pkg;
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_ZAZ   = 4'h1,
    OP_AZSZ  = 4'h2,
    OP_EDIT  = 4'h3,
    OP_CLC   = 4'h4,
    OP_CLI   = 4'h5,
    OP_ALC   = 4'h6,
    OP_SLC   = 4'h7,
    OP_SREG  = 4'h8,
    OP_TBON  = 4'h9,
    OP_TBOFF = 4'ha,
    OP_SRC   = 4'hb,
    OP_LOAD  = 4'hc
  } cfas_op_type;

  typedef struct packed {
    logic        valid;
    cfas_op_type op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  mask;
  } cfas_flag_req_type;
endpackage : cfas_pkg

// ==== hdl/cfas_top.sv ====
// Condition flags and address sequencing datapath slice
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "cfas_defs.svh"
module cfas_top #(
  parameter int ADDR_W = 16
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire cfas_pkg::cfas_flag_req_type i_flag_req,
  input  wire logic                  i_sp_reset,
  input  wire logic                  i_reg_load,
  input  wire logic                  i_reg_add,
  input  wire logic [7:0]            i_reg_add_val,
  input  wire logic                  i_br_valid,
  input  wire logic [7:0]            i_br_mask,
  input  wire logic                  i_br_on_true,
  input  wire logic [ADDR_W-1:0]     i_br_target,
  input  wire logic                  i_fetch_one,
  input  wire logic                  i_fetch_two,
  input  wire logic                  i_addr_direct,
  input  wire logic [ADDR_W-1:0]     i_direct_addr,
  input  wire logic                  i_addr_index,
  input  wire logic                  i_index_sel,
  input  wire logic [7:0]            i_disp,
  input  wire logic                  i_op_step,
  input  wire logic                  i_op_itc,
  input  wire logic [3:0]            i_addr,
  input  wire logic [15:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [15:0]                o_rdata,
  output logic [7:0]                 o_flags,
  output logic                       o_br_taken,
  output logic [ADDR_W-1:0]          o_iar,
  output logic [ADDR_W-1:0]          o_sar
);
  initial begin
    if (ADDR_W != 16) $error("cfas_top: ADDR_W must be 16");
  end

  // ----------------------------------------------------------------
  // Condition flags
  // ----------------------------------------------------------------
  logic [7:0]        flags_reg;
  logic [7:0]        flags_next;
  logic [ADDR_W-1:0] iar_reg;
  logic [ADDR_W-1:0] sar_reg;
  logic [ADDR_W-1:0] opa_reg;
  logic [ADDR_W-1:0] xr1_reg;
  logic [ADDR_W-1:0] xr2_reg;
  logic [7:0]        rd_a;
  logic [7:0]        rd_b;
  logic [8:0]        sum9;
  logic [8:0]        diff9;
  logic [7:0]        tmask;
  logic              br_hit;
  logic              edit_ok;
  logic              reg_wr_flags;
  logic [8:0]        add_sum;

  assign rd_a  = i_flag_req.a;
  assign rd_b  = i_flag_req.b;
  assign sum9  = {1'b0, rd_a} + {1'b0, rd_b};
  assign diff9 = {1'b0, rd_a} - {1'b0, rd_b};
  assign tmask = rd_a & i_flag_req.mask;
  // Add-to-register sum of write data low byte and addend
  assign add_sum = {1'b0, i_wdata[7:0]} + {1'b0, i_reg_add_val};
  assign reg_wr_flags = i_wr && (i_addr == `CFAS_ADDR_FLAGS);
  // Any selected flag set; true/false sense picks branch polarity
  assign br_hit = (|(flags_reg & i_br_mask)) == i_br_on_true;
  // Low byte 20 with zero flag set, or non-zero second operand
  assign edit_ok = (flags_reg[`CFAS_BIT_ZERO] && rd_a == `CFAS_EDIT_LOW_BYTE)
                   || (rd_b != 8'h00);

  // Three-way sign/compare result; a is result or operand 1
  function automatic logic [7:0] cmp3(input logic [7:0] f, input logic z,
                                      input logic n, input logic p);
    logic [7:0] r;
    r = f;
    r[`CFAS_BIT_ZERO] = z;
    r[`CFAS_BIT_NEG]  = n;
    r[`CFAS_BIT_POS]  = p;
    return r;
  endfunction : cmp3

  always_comb begin
    flags_next = flags_reg;
    if (i_flag_req.valid) begin
      unique case (i_flag_req.op)
        cfas_pkg::OP_ZAZ: begin
          // b carries the sign: 1 means negative
          flags_next = cmp3(flags_reg, rd_a == 8'h00, rd_a != 8'h00 && rd_b[0],
                            rd_a != 8'h00 && !rd_b[0]);
        end
        cfas_pkg::OP_AZSZ: begin
          flags_next = cmp3(flags_reg, rd_a == 8'h00, rd_a != 8'h00 && rd_b[0],
                            rd_a != 8'h00 && !rd_b[0]);
          // Overflow is sticky until a branch tests it
          if (rd_b[1]) flags_next[`CFAS_BIT_OVF] = 1'b1;
        end
        cfas_pkg::OP_EDIT: begin
          if (edit_ok) begin
            // mask[0] carries operand two sign
            flags_next = cmp3(flags_reg, rd_b == 8'h00,
                              rd_b != 8'h00 && i_flag_req.mask[0],
                              rd_b != 8'h00 && !i_flag_req.mask[0]);
          end
        end
        cfas_pkg::OP_CLC: begin
          flags_next = cmp3(flags_reg, rd_a == rd_b, rd_a < rd_b, rd_a > rd_b);
        end
        cfas_pkg::OP_CLI: begin
          flags_next = cmp3(flags_reg, rd_a == rd_b, rd_a < rd_b, rd_a > rd_b);
        end
        cfas_pkg::OP_ALC: begin
          flags_next = cmp3(flags_reg, sum9[7:0] == 8'h00,
                            sum9[7:0] != 8'h00 && !sum9[8],
                            sum9[7:0] != 8'h00 && sum9[8]);
          flags_next[`CFAS_BIT_CARRY] = sum9[8];
        end
        cfas_pkg::OP_SLC: begin
          flags_next = cmp3(flags_reg, diff9[7:0] == 8'h00, rd_a < rd_b,
                            rd_a > rd_b);
        end
        cfas_pkg::OP_SREG: begin
          // a is register, b is operand
          flags_next = cmp3(flags_reg, diff9[7:0] == 8'h00, rd_a < rd_b,
                            rd_a > rd_b);
        end
        cfas_pkg::OP_TBON: begin
          if (tmask != i_flag_req.mask) flags_next[`CFAS_BIT_TEST] = 1'b1;
        end
        cfas_pkg::OP_TBOFF: begin
          if (tmask != 8'h00) flags_next[`CFAS_BIT_TEST] = 1'b1;
        end
        cfas_pkg::OP_SRC: begin
          // a is the result after shifting, b[0] the bit moved out
          flags_next = cmp3(flags_reg, rd_a == 8'h00, rd_a != 8'h00 && !rd_a[0],
                            rd_a[0]);
          if (rd_b[0]) flags_next[`CFAS_BIT_CARRY] = 1'b1;
        end
        cfas_pkg::OP_LOAD: begin
          flags_next = rd_a;
        end
        default: begin
          flags_next = flags_reg;
        end
      endcase
    end else if (i_reg_add) begin
      flags_next = cmp3(flags_reg, add_sum[7:0] == 8'h00,
                        add_sum[7:0] != 8'h00 && !add_sum[8],
                        add_sum[7:0] != 8'h00 && add_sum[8]);
      flags_next[`CFAS_BIT_CARRY] = add_sum[8];
    end
    if (i_br_valid) begin
      // Tested test/overflow bits are consumed by the branch
      if (i_br_mask[`CFAS_BIT_TEST]) flags_next[`CFAS_BIT_TEST] = 1'b0;
      if (i_br_mask[`CFAS_BIT_OVF])  flags_next[`CFAS_BIT_OVF]  = 1'b0;
    end
    if (reg_wr_flags || i_reg_load) flags_next = i_wdata[7:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= `CFAS_FLAGS_RESET;
    end else if (i_sp_reset) begin
      flags_reg <= `CFAS_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------
  // Instruction address sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      iar_reg <= 16'h0000;
    end else if (i_br_valid && br_hit) begin
      iar_reg <= i_br_target;
    end else if (i_wr && i_addr == `CFAS_ADDR_IAR) begin
      iar_reg <= i_wdata;
    end else if (i_fetch_two) begin
      iar_reg <= iar_reg + 16'h0002;
    end else if (i_fetch_one) begin
      iar_reg <= iar_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Operand address generation
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] idx_base;
  logic [ADDR_W-1:0] idx_addr;
  assign idx_base = i_index_sel ? xr2_reg : xr1_reg;
  assign idx_addr = idx_base + {8'h00, i_disp};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opa_reg <= 16'h0000;
    end else if (i_addr_direct) begin
      opa_reg <= i_direct_addr;
    end else if (i_addr_index) begin
      opa_reg <= idx_addr;
    end else if (i_op_step) begin
      // Fields are addressed at their rightmost byte
      opa_reg <= i_op_itc ? opa_reg + 16'h0001 : opa_reg - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sar_reg <= 16'h0000;
    end else if (i_addr_direct) begin
      sar_reg <= i_direct_addr;
    end else if (i_addr_index) begin
      sar_reg <= idx_addr;
    end else if (i_op_step) begin
      sar_reg <= i_op_itc ? opa_reg + 16'h0001 : opa_reg - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xr1_reg <= 16'h0000;
      xr2_reg <= 16'h0000;
    end else if (i_wr) begin
      if (i_addr == `CFAS_ADDR_XR1) xr1_reg <= i_wdata;
      if (i_addr == `CFAS_ADDR_XR2) xr2_reg <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        `CFAS_ADDR_FLAGS: o_rdata <= {8'h00, flags_reg};
        `CFAS_ADDR_IAR:   o_rdata <= iar_reg;
        `CFAS_ADDR_SAR:   o_rdata <= sar_reg;
        `CFAS_ADDR_OPA:   o_rdata <= opa_reg;
        `CFAS_ADDR_XR1:   o_rdata <= xr1_reg;
        `CFAS_ADDR_XR2:   o_rdata <= xr2_reg;
        default:          o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  assign o_flags    = flags_reg;
  assign o_br_taken = i_br_valid && br_hit;
  assign o_iar      = iar_reg;
  assign o_sar      = sar_reg;
endmodule : cfas_top

// ==== bench/cfas_top_properties.sv ====
// Port-level assertions for the condition flags and address block
`timescale 1ns/10ps
module cfas_top_properties #(
  parameter int ADDR_W = 16
) (
  input wire logic                        i_clk,
  input wire logic                        i_rst_n,
  input wire cfas_pkg::cfas_flag_req_type i_flag_req,
  input wire logic                        i_sp_reset,
  input wire logic                        i_reg_load,
  input wire logic                        i_reg_add,
  input wire logic                        i_br_valid,
  input wire logic [7:0]                  i_br_mask,
  input wire logic [ADDR_W-1:0]           i_br_target,
  input wire logic                        i_fetch_one,
  input wire logic                        i_fetch_two,
  input wire logic                        i_addr_direct,
  input wire logic [ADDR_W-1:0]           i_direct_addr,
  input wire logic                        i_addr_index,
  input wire logic                        i_op_step,
  input wire logic                        i_op_itc,
  input wire logic [3:0]                  i_addr,
  input wire logic                        i_wr,
  input wire logic [7:0]                  o_flags,
  input wire logic                        o_br_taken,
  input wire logic [ADDR_W-1:0]           o_iar,
  input wire logic [ADDR_W-1:0]           o_sar
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic flag_wr;
  logic iar_wr;
  assign flag_wr = i_wr && (i_addr == 4'h0);
  assign iar_wr  = i_wr && (i_addr == 4'h1);
  property p_sp_reset;
    i_sp_reset |=> o_flags == 8'h01;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("flags not 01 after reset command");
  property p_clear;
    i_br_valid && i_br_mask == 8'h08 && !i_sp_reset && !i_reg_load && !flag_wr |=> !o_flags[3];
  endproperty
  a_clear: assert property (p_clear)
    else $error("tested bit not cleared");
  property p_taken;
    o_br_taken |=> o_iar == $past(i_br_target);
  endproperty
  a_taken: assert property (p_taken)
    else $error("target not loaded");
  property p_fetch;
    (i_fetch_one || i_fetch_two) && !o_br_taken && !iar_wr
      |=> o_iar == $past(o_iar) + ($past(i_fetch_two) ? 2 : 1);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("instruction address step wrong");
  property p_direct;
    i_addr_direct |=> o_sar == $past(i_direct_addr);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address altered");
  property p_step;
    i_op_step && !i_addr_direct && !i_addr_index
      |=> o_sar == ($past(i_op_itc) ? $past(o_sar) + 1 : $past(o_sar) - 1);
  endproperty
  a_step: assert property (p_step)
    else $error("operand address step wrong");
  property p_hold;
    !i_sp_reset && !i_reg_load && !i_reg_add && !i_br_valid && !i_flag_req.valid && !flag_wr
      |=> $stable(o_flags);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags changed without cause");
  property p_no_branch;
    !i_br_valid |-> !o_br_taken;
  endproperty
  a_no_branch: assert property (p_no_branch)
    else $error("taken without branch");
endmodule : cfas_top_properties

bind cfas_top cfas_top_properties #(.ADDR_W(ADDR_W)) i_props (
  .i_clk, .i_rst_n, .i_flag_req, .i_sp_reset, .i_reg_load, .i_reg_add, .i_br_valid,
  .i_br_mask, .i_br_target, .i_fetch_one, .i_fetch_two, .i_addr_direct, .i_direct_addr,
  .i_addr_index, .i_op_step, .i_op_itc, .i_addr, .i_wr, .o_flags, .o_br_taken, .o_iar,
  .o_sar
);

// ==== bench/cfas_sp_model.sv ====
// Service processor model driving the register port and commands
`timescale 1ns/10ps
module cfas_sp_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  output logic [3:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [2:0]       o_cmd
);
  // ---------------------------------------------------------------
  // Bus cycles, strobes one cycle long
  // ---------------------------------------------------------------
  initial begin
    {o_addr, o_wdata, o_wr, o_rd, o_cmd} = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1 d = i_rdata;
  endtask : rd
  // Command bits: reset, register load, add-to-register
  task automatic cmd(input logic [2:0] k, input logic [15:0] d);
    @(posedge i_clk);
    o_wdata <= d;
    o_cmd   <= k;
    @(posedge i_clk);
    o_cmd   <= 3'h0;
  endtask : cmd
endmodule : cfas_sp_model

// ==== bench/cfas_top_tb.sv ====
// Self-checking testbench for the condition flags and address block
`timescale 1ns/10ps
module cfas_top_tb;
  // ---------------------------------------------------------------
  // Stimulus, instances and scenarios
  // ---------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  cfas_pkg::cfas_flag_req_type req = '0;
  logic br_valid = 1'b0, br_on = 1'b0, dir = 1'b0, idx = 1'b0, sel = 1'b0;
  logic step = 1'b0, insert_test_characters = 1'b0, f_one = 1'b0, f_two = 1'b0;
  logic [7:0] br_mask = 8'h00, disp = 8'h10, add_val = 8'h02;
  logic [15:0] br_tgt = 16'hbee0, dir_addr = 16'h1234, d;
  wire logic [3:0] addr;
  wire logic [15:0] wdata, rdata, iar, sar;
  wire logic [7:0] flags;
  wire logic [2:0] cmd;
  wire logic wr, rd, taken;
  int n_fail = 0, comparisons = 0;
  always #5 i_clk = ~i_clk;
  cfas_sp_model i_sp (.i_clk, .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd), .o_cmd(cmd));
  cfas_top i_dut (.i_clk, .i_rst_n, .i_flag_req(req), .i_sp_reset(cmd[2]), .i_reg_load(cmd[1]),
    .i_reg_add(cmd[0]), .i_reg_add_val(add_val), .i_br_valid(br_valid), .i_br_mask(br_mask),
    .i_br_on_true(br_on), .i_br_target(br_tgt), .i_fetch_one(f_one), .i_fetch_two(f_two),
    .i_addr_direct(dir), .i_direct_addr(dir_addr), .i_addr_index(idx), .i_index_sel(sel),
    .i_disp(disp), .i_op_step(step), .i_op_itc(insert_test_characters), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_flags(flags), .o_br_taken(taken),
    .o_iar(iar), .o_sar(sar));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic fop(input cfas_pkg::cfas_op_type op, input logic [7:0] a, b, m, e);
    @(posedge i_clk);
    req <= '{1'b1, op, a, b, m};
    @(posedge i_clk);
    req.valid <= 1'b0;
    #1 chk("flags", {8'h00, e}, {8'h00, flags});
  endtask : fop
  task automatic brn(input logic [7:0] m, input logic on, t, input logic [7:0] e);
    @(posedge i_clk);
    {br_valid, br_mask, br_on} <= {1'b1, m, on};
    #1 chk("taken", {15'h0, t}, {15'h0, taken});
    @(posedge i_clk);
    br_valid <= 1'b0;
    #1 chk("flags", {8'h00, e}, {8'h00, flags});
    chk("iar", 16'hbee0, iar);
  endtask : brn
  // Vector order: direct, index, select, step, increment, fetch two, fetch one
  task automatic pul(input logic [6:0] s);
    @(posedge i_clk);
    {dir, idx, sel, step, insert_test_characters, f_two, f_one} <= s;
    @(posedge i_clk);
    {dir, idx, step, f_two, f_one} <= 5'h00;
    #1;
  endtask : pul
  task automatic t_regs;
    i_sp.rd(4'h0, d); chk("flags read", 16'h0001, d);
    i_sp.rd(4'hf, d); chk("unmapped", 16'h0000, d);
    i_sp.wr(4'h2, 16'hffff); i_sp.rd(4'h2, d); chk("sar ro", 16'h0000, d);
    i_sp.wr(4'h4, 16'h0100); i_sp.wr(4'h5, 16'h0200);
    i_sp.rd(4'h4, d); chk("xr1", 16'h0100, d);
    i_sp.rd(4'h5, d); chk("xr2", 16'h0200, d);
    $display("test regs done");
  endtask : t_regs
  task automatic t_addr;
    pul(7'b1000000); chk("sar", 16'h1234, sar);
    pul(7'b0001000); chk("sar", 16'h1233, sar);
    pul(7'b0001100); chk("sar", 16'h1234, sar);
    pul(7'b0100000); chk("sar", 16'h0110, sar);
    pul(7'b0110000); chk("sar", 16'h0210, sar);
    pul(7'b0000001); chk("iar", 16'h0001, iar);
    pul(7'b0000010); chk("iar", 16'h0003, iar);
    pul(7'b0000011); chk("iar", 16'h0005, iar);
    i_sp.rd(4'h3, d); chk("opa read", 16'h0210, d);
    i_sp.rd(4'h1, d); chk("iar read", 16'h0005, d);
    $display("test addr done");
  endtask : t_addr
  task automatic t_flags;
    fop(cfas_pkg::OP_LOAD, 8'h00, 8'h00, 8'h00, 8'h00);
    fop(cfas_pkg::OP_ZAZ, 8'h00, 8'h00, 8'h00, 8'h80);
    fop(cfas_pkg::OP_ZAZ, 8'h05, 8'h01, 8'h00, 8'h40);
    fop(cfas_pkg::OP_AZSZ, 8'h05, 8'h02, 8'h00, 8'h30);
    fop(cfas_pkg::OP_CLC, 8'h03, 8'h05, 8'h00, 8'h50);
    fop(cfas_pkg::OP_CLI, 8'h09, 8'h05, 8'h00, 8'h30);
    fop(cfas_pkg::OP_ALC, 8'hff, 8'h02, 8'h00, 8'h34);
    fop(cfas_pkg::OP_SLC, 8'h05, 8'h05, 8'h00, 8'h94);
    fop(cfas_pkg::OP_SREG, 8'h02, 8'h07, 8'h00, 8'h54);
    fop(cfas_pkg::OP_TBON, 8'h0f, 8'h00, 8'hff, 8'h5c);
    brn(8'h08, 1'b1, 1'b1, 8'h54);
    fop(cfas_pkg::OP_TBOFF, 8'h00, 8'h00, 8'hff, 8'h54);
    fop(cfas_pkg::OP_TBOFF, 8'h01, 8'h00, 8'h01, 8'h5c);
    brn(8'h08, 1'b0, 1'b0, 8'h54);
    brn(8'h10, 1'b1, 1'b1, 8'h44);
    fop(cfas_pkg::OP_SRC, 8'h03, 8'h00, 8'h00, 8'h24);
    fop(cfas_pkg::OP_SRC, 8'h02, 8'h01, 8'h00, 8'h44);
    fop(cfas_pkg::OP_EDIT, 8'h20, 8'h00, 8'h00, 8'h44);
    fop(cfas_pkg::OP_EDIT, 8'h00, 8'h03, 8'h00, 8'h24);
    fop(cfas_pkg::OP_EDIT, 8'h00, 8'h03, 8'h01, 8'h44);
    i_sp.cmd(3'h1, 16'h00ff); #1 chk("flags", 16'h0024, {8'h00, flags});
    i_sp.cmd(3'h2, 16'h00a5); #1 chk("flags", 16'h00a5, {8'h00, flags});
    i_sp.cmd(3'h4, 16'h0000); #1 chk("flags", 16'h0001, {8'h00, flags});
    $display("test flags done");
  endtask : t_flags
  // Hang guard: far beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_addr();
    t_flags();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    #1 chk("flags", 16'h0001, {8'h00, flags});
    chk("iar", 16'h0000, iar);
    stop_test();
  end
endmodule : cfas_top_tb
